/* File: core/rac_defines.svh */
// Register indices, field masks, reset values and widths of the register bank
`ifndef RAC_DEFINES_SVH
`define RAC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define RAC_DATA_W        8
`define RAC_ADDR_W        3

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define RAC_IDX_CTRL      3'h0
`define RAC_IDX_STATUS    3'h1
`define RAC_IDX_CMD       3'h2
`define RAC_IDX_OUT       3'h3
`define RAC_IDX_OUTSET    3'h4
`define RAC_IDX_OUTCLEAR  3'h5
`define RAC_IDX_OUTTOGGLE 3'h6
`define RAC_IDX_DBG       3'h7

// ----------------------------------------------------------------------------
// Implemented bit masks (zero bits are reserved)
// ----------------------------------------------------------------------------
`define RAC_MASK_CTRL     8'h3F
`define RAC_MASK_STATUS   8'h7F
`define RAC_MASK_CMD      8'h0F
`define RAC_MASK_OUT      8'hFF
`define RAC_MASK_DBG      8'h03

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RAC_RST_CTRL      8'h00
`define RAC_RST_OUT       8'h00
`define RAC_RST_DBG       8'h00
`define RAC_RST_CMD       8'h00
`define RAC_RST_RDATA     8'h00

`endif

/* File: core/rac_pkg.sv */
// Types and shared operations of the register bank
package rac_pkg;

  // --------------------------------------------------------------------------
  // Pair access kinds
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    RAC_OP_BASE = 4'h1,
    RAC_OP_SET  = 4'h2,
    RAC_OP_CLEAR  = 4'h4,
    RAC_OP_TOGGLE = 4'h8
  } rac_op_t;

  typedef logic [7:0] rac_data_t;

  // --------------------------------------------------------------------------
  // New base value for one write through any address of a pair
  // --------------------------------------------------------------------------
  function automatic rac_data_t rac_apply(input rac_op_t op, input rac_data_t cur, input rac_data_t wd);
    rac_data_t res;
    res = cur;
    case (op)
      RAC_OP_BASE: res = wd;
      RAC_OP_SET:  res = cur | wd;
      RAC_OP_CLEAR:  res = cur & ~wd;
      RAC_OP_TOGGLE: res = cur ^ wd;
      default:     res = cur;
    endcase
    return res;
  endfunction : rac_apply

  // --------------------------------------------------------------------------
  // Maps an index onto the pair access kind
  // --------------------------------------------------------------------------
  function automatic rac_op_t rac_op_of(input logic [2:0] idx);
    rac_op_t op;
    case (idx)
      3'h4:    op = RAC_OP_SET;
      3'h5:    op = RAC_OP_CLEAR;
      3'h6:    op = RAC_OP_TOGGLE;
      default: op = RAC_OP_BASE;
    endcase
    return op;
  endfunction : rac_op_of

endpackage : rac_pkg

/* File: core/rac_pair_if.sv */
// Link between the bank and its set/clear/toggle register pair
`timescale 1ns/100ps

interface rac_pair_if;
  logic              wr;
  rac_pkg::rac_op_t  op;
  rac_pkg::rac_data_t wdata;
  logic              srst;
  rac_pkg::rac_data_t val;

  modport bank (output wr, output op, output wdata, output srst, input val);
  modport pair (input wr, input op, input wdata, input srst, output val);
endinterface : rac_pair_if

/* File: core/rac_pair.sv */
// Base register with set, clear and toggle companions
`timescale 1ns/100ps
`include "rac_defines.svh"

module rac_pair (
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  input  wire logic  ce_i,
  // Bank side
  rac_pair_if.pair   pif
);

  rac_pkg::rac_data_t val_q;
  rac_pkg::rac_data_t val_d;

  // --------------------------------------------------------------------------
  // Next value
  // --------------------------------------------------------------------------
  always_comb begin
    val_d = val_q;
    if (pif.srst) begin
      val_d = `RAC_RST_OUT;
    end else if (pif.wr) begin
      // Zero bits of a companion write keep their value
      val_d = rac_pkg::rac_apply(pif.op, val_q, pif.wdata) & `RAC_MASK_OUT;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      val_q <= `RAC_RST_OUT;
    end else if (ce_i) begin
      val_q <= val_d;
    end
  end

  // One stored value behind all four addresses
  assign pif.val = val_q;

endmodule : rac_pair

/* File: core/rac_top.sv */
// Register bank showing read/write, read-only, write-only, reserved and paired bits
// Summary of operation
// - Read/write bits store written data and return it on reads.
// - Read-only bits show hardware state; writes to them are dropped.
// - Write-only bits accept writes; their read value must not be relied on.
// - Reserved bits always read as zero whatever was written.
// - Every register holds its reset value after power-on reset.
// - Peripheral soft reset restores reset values except debug control registers.
// - Each companion register pairs one base; both addresses read the same value.
// - A one written to the clear companion forces that base bit to zero.
// - A one written to the set companion forces that base bit to one.
// - A one written to the toggle companion inverts that base bit.
`timescale 1ns/100ps
`include "rac_defines.svh"

module rac_top (
  // Clock, reset, enable
  input  wire logic                       CLK_I,
  input  wire logic                       RST_N_I,
  input  wire logic                       CE_I,
  input  wire logic                       SWRST_I,
  // Register access port
  input  wire logic                       REQ_I,
  input  wire logic                       WE_I,
  input  wire logic [`RAC_ADDR_W-1:0]     ADDR_I,
  input  wire logic [`RAC_DATA_W-1:0]     WDATA_I,
  output logic      [`RAC_DATA_W-1:0]     RDATA_O,
  output logic                            ACK_O,
  // Hardware side
  input  wire logic [`RAC_DATA_W-1:0]     STATUS_I,
  output logic      [`RAC_DATA_W-1:0]     CTRL_O,
  output logic      [`RAC_DATA_W-1:0]     CMD_O,
  output logic                            CMD_STB_O,
  output logic      [`RAC_DATA_W-1:0]     OUT_O,
  output logic      [`RAC_DATA_W-1:0]     DBG_O
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  rac_pkg::rac_data_t ctrl_q;
  rac_pkg::rac_data_t ctrl_d;
  rac_pkg::rac_data_t dbg_q;
  rac_pkg::rac_data_t dbg_d;
  rac_pkg::rac_data_t cmd_q;
  rac_pkg::rac_data_t cmd_d;
  logic               cmd_stb_q;
  logic               cmd_stb_d;
  rac_pkg::rac_data_t rdata_q;
  rac_pkg::rac_data_t rdata_d;
  logic               ack_q;
  logic               ack_d;
  logic               wr;
  logic               rd;
  logic               is_pair;
  logic               wr_ctrl;
  logic               wr_dbg;
  logic               wr_cmd;
  rac_pkg::rac_data_t status_view;

  rac_pair_if pif ();

  // --------------------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------------------
  // Index of the base register or one of its companions
  function automatic logic rac_in_pair(input logic [`RAC_ADDR_W-1:0] idx);
    return (idx >= `RAC_IDX_OUT) && (idx <= `RAC_IDX_OUTTOGGLE);
  endfunction : rac_in_pair

  // Implemented bits of an index; zero bits are reserved
  function automatic rac_pkg::rac_data_t rac_mask_of(input logic [`RAC_ADDR_W-1:0] idx);
    rac_pkg::rac_data_t m;
    case (idx)
      `RAC_IDX_CTRL:   m = `RAC_MASK_CTRL;
      `RAC_IDX_STATUS: m = `RAC_MASK_STATUS;
      `RAC_IDX_CMD:    m = `RAC_MASK_CMD;
      `RAC_IDX_DBG:    m = `RAC_MASK_DBG;
      default:         m = `RAC_MASK_OUT;
    endcase
    return m;
  endfunction : rac_mask_of

  assign wr      = REQ_I & WE_I;
  assign rd      = REQ_I & ~WE_I;
  assign is_pair = rac_in_pair(ADDR_I);

  // --------------------------------------------------------------------------
  // Write strobes
  // --------------------------------------------------------------------------
  assign wr_ctrl = wr & (ADDR_I == `RAC_IDX_CTRL);
  assign wr_dbg  = wr & (ADDR_I == `RAC_IDX_DBG);
  assign wr_cmd  = wr & (ADDR_I == `RAC_IDX_CMD);

  // --------------------------------------------------------------------------
  // Read-only status
  // --------------------------------------------------------------------------
  // No store stands behind the status index, so a write there changes nothing
  assign status_view = STATUS_I & rac_mask_of(`RAC_IDX_STATUS);

  // --------------------------------------------------------------------------
  // Paired register
  // --------------------------------------------------------------------------
  assign pif.wr    = wr & is_pair;
  assign pif.op    = rac_pkg::rac_op_of(ADDR_I);
  assign pif.wdata = WDATA_I;
  assign pif.srst  = SWRST_I;

  rac_pair u_pair (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .ce_i    (CE_I),
    .pif     (pif)
  );

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    if (SWRST_I) begin
      // Soft reset wins over a write in the same cycle
      ctrl_d = `RAC_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_d = WDATA_I & rac_mask_of(ADDR_I);
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_q <= `RAC_RST_CTRL;
    end else if (CE_I) begin
      ctrl_q <= ctrl_d;
    end
  end

  // --------------------------------------------------------------------------
  // Debug control register, kept through a soft reset
  // --------------------------------------------------------------------------
  always_comb begin
    dbg_d = dbg_q;
    if (wr_dbg) begin
      dbg_d = WDATA_I & rac_mask_of(ADDR_I);
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dbg_q <= `RAC_RST_DBG;
    end else if (CE_I) begin
      dbg_q <= dbg_d;
    end
  end

  // --------------------------------------------------------------------------
  // Write-only command
  // --------------------------------------------------------------------------
  always_comb begin
    cmd_d     = cmd_q;
    cmd_stb_d = 1'b0;
    if (SWRST_I) begin
      cmd_d = `RAC_RST_CMD;
    end else if (wr_cmd) begin
      cmd_d     = WDATA_I & rac_mask_of(ADDR_I);
      cmd_stb_d = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cmd_q     <= `RAC_RST_CMD;
      cmd_stb_q <= 1'b0;
    end else if (CE_I) begin
      cmd_q     <= cmd_d;
      cmd_stb_q <= cmd_stb_d;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  always_comb begin
    ack_d   = REQ_I;
    rdata_d = rdata_q;
    if (rd) begin
      if (is_pair) begin
        rdata_d = pif.val;
      end else begin
        case (ADDR_I)
          `RAC_IDX_CTRL:   rdata_d = ctrl_q & rac_mask_of(ADDR_I);
          `RAC_IDX_STATUS: rdata_d = status_view;
          // Write-only data is not returned
          `RAC_IDX_CMD:    rdata_d = 8'h00;
          `RAC_IDX_DBG:    rdata_d = dbg_q & rac_mask_of(ADDR_I);
          default:         rdata_d = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_q <= `RAC_RST_RDATA;
      ack_q   <= 1'b0;
    end else if (CE_I) begin
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign RDATA_O   = rdata_q;
  assign ACK_O     = ack_q;
  assign CTRL_O    = ctrl_q;
  assign CMD_O     = cmd_q;
  assign CMD_STB_O = cmd_stb_q;
  assign OUT_O     = pif.val;
  assign DBG_O     = dbg_q;

endmodule : rac_top

/* File: sim/rac_monitor.sv */
// Concurrent checks on the register bank ports
`timescale 1ns/100ps
`include "rac_defines.svh"

module rac_monitor (
  // Clock and control
  input wire logic                   CLK_I,
  input wire logic                   RST_N_I,
  input wire logic                   CE_I,
  input wire logic                   SWRST_I,
  // Access port
  input wire logic                   REQ_I,
  input wire logic                   WE_I,
  input wire logic [`RAC_ADDR_W-1:0] ADDR_I,
  input wire logic [`RAC_DATA_W-1:0] WDATA_I,
  input wire logic [`RAC_DATA_W-1:0] RDATA_O,
  input wire logic                   ACK_O,
  // Hardware side
  input wire logic [`RAC_DATA_W-1:0] STATUS_I,
  input wire logic [`RAC_DATA_W-1:0] CTRL_O,
  input wire logic [`RAC_DATA_W-1:0] CMD_O,
  input wire logic                   CMD_STB_O,
  input wire logic [`RAC_DATA_W-1:0] OUT_O,
  input wire logic [`RAC_DATA_W-1:0] DBG_O
);
  wire rd = CE_I && REQ_I && !WE_I;
  wire wr = CE_I && REQ_I && WE_I && !SWRST_I;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  chk_ack_pulse: assert property (CE_I && REQ_I |=> ACK_O) else $error("ack missing");
  chk_ack_idle: assert property (CE_I && !REQ_I |=> !ACK_O) else $error("stray ack");
  chk_ctrl_store: assert property (wr && ADDR_I == `RAC_IDX_CTRL
    |=> CTRL_O == ($past(WDATA_I) & `RAC_MASK_CTRL)) else $error("ctrl store wrong");
  chk_status_read: assert property (rd && ADDR_I == `RAC_IDX_STATUS
    |=> RDATA_O == ($past(STATUS_I) & `RAC_MASK_STATUS)) else $error("status read wrong");
  chk_pair_read: assert property (rd && ADDR_I >= 3'h3 && ADDR_I <= 3'h6
    |=> RDATA_O == $past(OUT_O)) else $error("pair read wrong");
  chk_set_bits: assert property (wr && ADDR_I == `RAC_IDX_OUTSET
    |=> OUT_O == ($past(OUT_O) | $past(WDATA_I))) else $error("set wrong");
  chk_clear_bits: assert property (wr && ADDR_I == `RAC_IDX_OUTCLEAR
    |=> OUT_O == ($past(OUT_O) & ~$past(WDATA_I))) else $error("clear wrong");
  chk_toggle_bits: assert property (wr && ADDR_I == `RAC_IDX_OUTTOGGLE
    |=> OUT_O == ($past(OUT_O) ^ $past(WDATA_I))) else $error("toggle wrong");
  chk_soft_clear: assert property (CE_I && SWRST_I && !REQ_I
    |=> CTRL_O == 8'h00 && OUT_O == 8'h00 && $stable(DBG_O)) else $error("soft reset wrong");
  chk_reserved_zero: assert property (CTRL_O[7:6] == 2'h0 && DBG_O[7:2] == 6'h00 && CMD_O[7:4] == 4'h0)
    else $error("reserved bit set");
endmodule : rac_monitor

bind rac_top rac_monitor rac_monitor_inst (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .SWRST_I(SWRST_I),
  .REQ_I(REQ_I), .WE_I(WE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .ACK_O(ACK_O),
  .STATUS_I(STATUS_I), .CTRL_O(CTRL_O), .CMD_O(CMD_O), .CMD_STB_O(CMD_STB_O), .OUT_O(OUT_O), .DBG_O(DBG_O));

/* File: sim/tb_top.sv */
// Self-checking bench for the register bank
`timescale 1ns/100ps

module tb_top;
  logic       clk = 1'b0, rst_n = 1'b0, ce = 1'b1, swrst = 1'b0, req = 1'b0, we = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, status = 8'h00;
  logic [7:0] rdata, ctrl, cmd, outv, dbg;
  logic       ack, cmd_stb;
  int         num_errors = 0, samples_checked = 0, cycles = 0;

  always #2 clk = ~clk;

  rac_top rac_top_inst (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .SWRST_I(swrst), .REQ_I(req), .WE_I(we),
    .ADDR_I(addr), .WDATA_I(wdata), .RDATA_O(rdata), .ACK_O(ack), .STATUS_I(status), .CTRL_O(ctrl),
    .CMD_O(cmd), .CMD_STB_O(cmd_stb), .OUT_O(outv), .DBG_O(dbg));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Request held from one falling edge to the next; the answer is judged there
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    req = 1'b1; we = w; addr = a; wdata = d;
    @(negedge clk);
    chk("ack", 8'h01, {7'h00, ack});
  endtask : acc

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk("rdata", e, rdata);
  endtask : rd

  task automatic idle;
    req = 1'b0;
    @(negedge clk);
  endtask : idle

  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    chk("ctrl", 8'h00, ctrl);
    chk("out", 8'h00, outv);
    chk("dbg", 8'h00, dbg);
    rd(3'h0, 8'h00);
    rd(3'h3, 8'h00);
    rd(3'h7, 8'h00);
    idle;
  endtask : t_reset

  task automatic t_rw;
    acc(1'b1, 3'h0, 8'hFF);
    chk("ctrl", 8'h3F, ctrl);
    acc(1'b1, 3'h7, 8'hFE);
    chk("dbg", 8'h02, dbg);
    rd(3'h0, 8'h3F);
    rd(3'h7, 8'h02);
    idle;
  endtask : t_rw

  // A control write while the enable is low must leave the control register as it was and raise no ack
  task automatic t_hold;
    ce = 1'b0;
    req = 1'b1;
    we = 1'b1;
    addr = 3'h0;
    wdata = 8'h2A;
    @(negedge clk);
    chk("ctrl", 8'h3F, ctrl);
    chk("ack", 8'h00, {7'h00, ack});
    req = 1'b0;
    ce = 1'b1;
    @(negedge clk);
    acc(1'b1, 3'h0, 8'h2A);
    chk("ctrl", 8'h2A, ctrl);
    idle;
  endtask : t_hold

  task automatic t_ro;
    status = 8'hA5;
    acc(1'b1, 3'h1, 8'h00);
    rd(3'h1, 8'h25);
    status = 8'h5A;
    rd(3'h1, 8'h5A);
    idle;
  endtask : t_ro

  task automatic t_wo;
    acc(1'b1, 3'h2, 8'hA5);
    chk("cmd", 8'h05, cmd);
    chk("cmd_stb", 8'h01, {7'h00, cmd_stb});
    idle;
    chk("cmd_stb", 8'h00, {7'h00, cmd_stb});
  endtask : t_wo

  task automatic t_pair;
    acc(1'b1, 3'h3, 8'h3C);
    chk("out", 8'h3C, outv);
    acc(1'b1, 3'h4, 8'h81);
    chk("out", 8'hBD, outv);
    acc(1'b1, 3'h5, 8'h0C);
    chk("out", 8'hB1, outv);
    acc(1'b1, 3'h6, 8'hFF);
    chk("out", 8'h4E, outv);
    acc(1'b1, 3'h6, 8'h00);
    chk("out", 8'h4E, outv);
    for (int i = 3; i < 7; i++) rd(i[2:0], 8'h4E);
    idle;
  endtask : t_pair

  task automatic t_soft;
    acc(1'b1, 3'h0, 8'h15);
    acc(1'b1, 3'h3, 8'h77);
    idle;
    swrst = 1'b1;
    @(negedge clk);
    swrst = 1'b0;
    chk("ctrl", 8'h00, ctrl);
    chk("out", 8'h00, outv);
    chk("dbg", 8'h02, dbg);
    acc(1'b1, 3'h3, 8'h55);
    idle;
    rst_n = 1'b0;
    #1;
    chk("out", 8'h00, outv);
    chk("dbg", 8'h00, dbg);
    @(negedge clk);
    rst_n = 1'b1;
    rd(3'h7, 8'h00);
    idle;
  endtask : t_soft

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_rw();
    t_hold();
    t_ro();
    t_wo();
    t_pair();
    t_soft();
    stop_test();
  end
endmodule : tb_top
